// file: common/icc_pkg.sv
// package for the input capture channel: register map, fields, modes
// assumes a 16-bit plain register port and one 125 MHz clock
package icc_pkg;
    localparam int ICC_AW = 4;
    localparam int ICC_DW = 16;
    localparam int ICC_FIFO_DEPTH = 4;
    localparam int ICC_PTR_W = 2;
    localparam logic [3:0] ICC_OFF_CONTROL = 4'h0;
    localparam logic [3:0] ICC_OFF_BUFFER = 4'h1;
    localparam logic [3:0] ICC_OFF_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ICC_OFF_IRQ_MASK = 4'h3;
    localparam int ICC_BIT_SIDL = 13;
    localparam int ICC_BIT_TMR = 7;
    localparam int ICC_BIT_CPI_HI = 6;
    localparam int ICC_BIT_CPI_LO = 5;
    localparam int ICC_BIT_OVF = 4;
    localparam int ICC_BIT_BNE = 3;
    localparam int ICC_BIT_MODE_HI = 2;
    localparam logic [15:0] ICC_CTRL_WMASK = 16'h20E7;
    localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
    localparam int ICC_IRQ_CAPTURE = 0;
    localparam int ICC_IRQ_OVERFLOW = 1;
    localparam int ICC_IRQ_WAKE = 2;
    localparam logic [2:0] ICC_IRQ_RESET = 3'h0;
    localparam logic [3:0] ICC_PRESCALE_4 = 4'h3;
    localparam logic [3:0] ICC_PRESCALE_16 = 4'hF;

    typedef enum logic [2:0] {
        ICC_MODE_OFF = 3'b000,
        ICC_MODE_BOTH = 3'b001,
        ICC_MODE_FALL = 3'b010,
        ICC_MODE_RISE = 3'b011,
        ICC_MODE_RISE4 = 3'b100,
        ICC_MODE_RISE16 = 3'b101,
        ICC_MODE_UNUSED = 3'b110,
        ICC_MODE_WAKE = 3'b111
    } icc_mode_t;

    typedef struct packed {
        logic [ICC_AW-1:0] addr;
        logic [ICC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } icc_bus_req_t;
endpackage : icc_pkg

// file: hdl/icc_fifo.sv
// capture buffer: small fifo of timer values
// assumes push/pop come from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module icc_fifo
    import icc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic flush_in,
    input wire logic push_valid_in,
    output logic push_ready_out,
    input wire logic [ICC_DW-1:0] push_data_in,
    output logic pop_valid_out,
    input wire logic pop_ready_in,
    output logic [ICC_DW-1:0] pop_data_out
);
    logic [ICC_DW-1:0] mem_r [ICC_FIFO_DEPTH];
    logic [ICC_PTR_W-1:0] wp_r;
    logic [ICC_PTR_W-1:0] rp_r;
    logic [ICC_PTR_W:0] cnt_r;
    wire push_w = push_valid_in && push_ready_out;
    wire pop_w = pop_valid_out && pop_ready_in;

    assign push_ready_out = (cnt_r != (ICC_PTR_W+1)'(ICC_FIFO_DEPTH));
    assign pop_valid_out = (cnt_r != '0);
    assign pop_data_out = mem_r[rp_r];

    always_ff @(posedge clk_in) begin
        if (reset_in || flush_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push_w) begin
                mem_r[wp_r] <= push_data_in;
                wp_r <= wp_r + 1'b1;
            end
            if (pop_w) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push_w && !pop_w) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop_w && !push_w) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // icc_fifo
`default_nettype wire

// file: hdl/icc_channel.sv
// input capture channel: edge detect, prescale, timer latch, buffer, irq
// assumes pin input asynchronous; timers and idle/sleep on clk_in
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module icc_channel
    import icc_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic capture_pin_in,
    input wire logic cpu_idle_in,
    input wire logic cpu_sleep_in,
    input wire logic [ICC_DW-1:0] timer_b_in,
    input wire logic [ICC_DW-1:0] timer_c_in,
    input wire logic [ICC_AW-1:0] reg_addr_in,
    input wire logic [ICC_DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ICC_DW-1:0] reg_rdata_out,
    output logic irq_out
);
    icc_bus_req_t req;
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    function automatic logic is_at(input logic [ICC_AW-1:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    logic [ICC_DW-1:0] ctrl_r;
    logic ovf_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [ICC_DW-1:0] rdata_r;
    logic [1:0] sync_r;
    logic pin_prev_r;
    logic [3:0] pre_r;
    logic [1:0] cpi_cnt_r;

    // sync_r[0] read only by sync_r[1]
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync_r <= 2'h0;
            pin_prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[0], capture_pin_in};
            pin_prev_r <= sync_r[1];
        end
    end

    wire pin_w = sync_r[1];
    wire rise_w = pin_w && !pin_prev_r;
    wire fall_w = !pin_w && pin_prev_r;
    icc_mode_t mode_w;
    assign mode_w = icc_mode_t'(ctrl_r[ICC_BIT_MODE_HI:0]);
    wire [1:0] cpi_w = ctrl_r[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO];

    wire halted_w = ctrl_r[ICC_BIT_SIDL] && cpu_idle_in;

    logic edge_w;
    always_comb begin
        case (mode_w)
            ICC_MODE_BOTH: edge_w = rise_w || fall_w;
            ICC_MODE_FALL: edge_w = fall_w;
            ICC_MODE_RISE: edge_w = rise_w;
            ICC_MODE_RISE4: edge_w = rise_w && (pre_r[1:0] == ICC_PRESCALE_4[1:0]);
            ICC_MODE_RISE16: edge_w = rise_w && (pre_r == ICC_PRESCALE_16);
            default: edge_w = 1'b0;
        endcase
    end
    wire capture_w = edge_w && !halted_w;

    // wake interrupt, rising edge in sleep or idle only
    wire wake_w = (mode_w == ICC_MODE_WAKE) && rise_w && (cpu_sleep_in || cpu_idle_in);

    // prescaler, cleared whenever a non-prescaled mode is selected
    wire prescaled_w = (mode_w == ICC_MODE_RISE4) || (mode_w == ICC_MODE_RISE16);
    always_ff @(posedge clk_in) begin
        if (reset_in || !prescaled_w) begin
            pre_r <= 4'h0;
        end else if (rise_w && !halted_w) begin
            pre_r <= pre_r + 4'h1;
        end
    end

    wire [ICC_DW-1:0] stamp_w = ctrl_r[ICC_BIT_TMR] ? timer_b_in : timer_c_in;

    logic fifo_ready_w;
    logic fifo_valid_w;
    logic [ICC_DW-1:0] fifo_data_w;
    wire buf_rd_w = req.rd && is_at(req.addr, ICC_OFF_BUFFER);
    // turning the channel off flushes stale captures
    wire flush_w = (mode_w == ICC_MODE_OFF);

    icc_fifo u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .flush_in(flush_w),
        .push_valid_in(capture_w),
        .push_ready_out(fifo_ready_w),
        .push_data_in(stamp_w),
        .pop_valid_out(fifo_valid_w),
        .pop_ready_in(buf_rd_w),
        .pop_data_out(fifo_data_w)
    );

    // overflow when full, cleared by hardware once the buffer drains
    wire ovf_set_w = capture_w && !fifo_ready_w;
    always_ff @(posedge clk_in) begin
        if (reset_in || flush_w) begin
            ovf_r <= 1'b0;
        end else if (ovf_set_w) begin
            ovf_r <= 1'b1;
        end else if (!fifo_valid_w) begin
            ovf_r <= 1'b0;
        end
    end

    // captures per interrupt; both-edge mode fires every capture
    wire [1:0] cpi_eff_w = (mode_w == ICC_MODE_BOTH) ? 2'h0 : cpi_w;
    wire cpi_hit_w = capture_w && (cpi_cnt_r == cpi_eff_w);
    always_ff @(posedge clk_in) begin
        if (reset_in || flush_w) begin
            cpi_cnt_r <= 2'h0;
        end else if (cpi_hit_w) begin
            cpi_cnt_r <= 2'h0;
        end else if (capture_w) begin
            cpi_cnt_r <= cpi_cnt_r + 2'h1;
        end
    end

    // register writes
    wire ctrl_wr_w = req.wr && is_at(req.addr, ICC_OFF_CONTROL);
    wire stat_wr_w = req.wr && is_at(req.addr, ICC_OFF_IRQ_STATUS);
    wire mask_wr_w = req.wr && is_at(req.addr, ICC_OFF_IRQ_MASK);
    wire [2:0] irq_ev_w = {wake_w, ovf_set_w, cpi_hit_w};
    wire [2:0] irq_clr_w = stat_wr_w ? req.wdata[2:0] : 3'h0;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r <= ICC_CTRL_RESET;
            irq_mask_r <= ICC_IRQ_RESET;
            irq_stat_r <= ICC_IRQ_RESET;
        end else begin
            if (ctrl_wr_w) begin
                ctrl_r <= req.wdata & ICC_CTRL_WMASK;
            end
            if (mask_wr_w) begin
                irq_mask_r <= req.wdata[2:0];
            end
            // set wins over write-one-to-clear
            irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_ev_w;
        end
    end

    logic [ICC_DW-1:0] ctrl_view_w;
    always_comb begin
        ctrl_view_w = ctrl_r;
        ctrl_view_w[ICC_BIT_OVF] = ovf_r;
        ctrl_view_w[ICC_BIT_BNE] = fifo_valid_w;
    end

    wire [ICC_DW-1:0] rd_mux_w =
        is_at(req.addr, ICC_OFF_CONTROL) ? ctrl_view_w :
        is_at(req.addr, ICC_OFF_BUFFER) ? fifo_data_w :
        is_at(req.addr, ICC_OFF_IRQ_STATUS) ? {13'h0000, irq_stat_r} :
        is_at(req.addr, ICC_OFF_IRQ_MASK) ? {13'h0000, irq_mask_r} : 16'h0000;

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_r <= 16'h0000;
        end else if (req.rd) begin
            rdata_r <= rd_mux_w;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ---- assertions
    ctrl_reserved_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (ctrl_r & ~ICC_CTRL_WMASK) == 16'h0000)
        else $error("reserved control bits set");
    timer_pick_a: assert property (@(posedge clk_in) disable iff (reset_in)
        capture_w && fifo_ready_w && !flush_w |=>
        u_fifo.mem_r[$past(u_fifo.wp_r)] ==
        ($past(ctrl_r[ICC_BIT_TMR]) ? $past(timer_b_in) : $past(timer_c_in)))
        else $error("wrong timer captured");
    idle_halt_a: assert property (@(posedge clk_in) disable iff (reset_in)
        halted_w |-> !capture_w)
        else $error("capture while halted in idle");
    mode_off_a: assert property (@(posedge clk_in) disable iff (reset_in)
        (mode_w == ICC_MODE_OFF || mode_w == ICC_MODE_UNUSED) |-> !capture_w)
        else $error("capture while disabled");
    fall_mode_a: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_w == ICC_MODE_FALL && !halted_w |-> capture_w == (!sync_r[1] && pin_prev_r))
        else $error("falling capture mismatch");
    rise_mode_a: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_w == ICC_MODE_RISE && !halted_w |-> capture_w == (sync_r[1] && !pin_prev_r))
        else $error("rising capture mismatch");
    wake_only_a: assert property (@(posedge clk_in) disable iff (reset_in)
        wake_w |-> !capture_w && (cpu_sleep_in || cpu_idle_in))
        else $error("wake mode misbehaves");
    ovf_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ovf_set_w && !flush_w |=> ovf_r)
        else $error("overflow not flagged");
    bne_flag_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ctrl_view_w[ICC_BIT_BNE] == (u_fifo.cnt_r != 3'h0))
        else $error("buffer not empty flag wrong");
    cpi_irq_a: assert property (@(posedge clk_in) disable iff (reset_in)
        cpi_hit_w |-> cpi_cnt_r == cpi_eff_w)
        else $error("interrupt count wrong");
    both_cpi_a: assert property (@(posedge clk_in) disable iff (reset_in)
        mode_w == ICC_MODE_BOTH && capture_w |-> cpi_hit_w)
        else $error("both-edge interrupt skipped");
    // a pop in the overflow cycle legally frees one slot, so leave it out
    no_overwrite_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ovf_set_w && !buf_rd_w && !flush_w |=> u_fifo.cnt_r == 3'h4)
        else $error("full buffer changed on overflow");
    rdata_idle_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !req.rd |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read slot");

    cap_seen_c: cover property (@(posedge clk_in) capture_w && fifo_ready_w);
    ovf_seen_c: cover property (@(posedge clk_in) ovf_set_w);
    wake_seen_c: cover property (@(posedge clk_in) wake_w);
    irq_seen_c: cover property (@(posedge clk_in) irq_out);
endmodule // icc_channel
`default_nettype wire

// file: sim/icc_pin_model.sv
// pin model: the external signal on the mapped capture input
// assumes the bench clock; the pin idles low and only moves on command
`timescale 1ns/1ns
`default_nettype none
module icc_pin_model (
    input wire logic clk_in,
    output logic pin_out
);
    initial pin_out = 1'b0;
    task automatic drive(input logic lvl);
        @(posedge clk_in);
        pin_out <= lvl;
        // covers two sync flops plus edge detect, with margin
        repeat (6) @(posedge clk_in);
    endtask
endmodule // icc_pin_model
`default_nettype wire

// file: sim/icc_channel_tb_top.sv
// bench for the input capture channel: modes, prescale, buffer, irq, idle
// assumes the pin model stands for the mapped signal; timers held per edge
`timescale 1ns/1ns
`default_nettype none
module icc_channel_tb_top;
    import icc_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [ICC_AW-1:0] addr = '0;
    logic [ICC_DW-1:0] wdata = '0;
    logic [ICC_DW-1:0] tb = '0;
    logic [ICC_DW-1:0] tc = '0;
    logic [ICC_DW-1:0] rdata, got, exp;
    logic irq, pin, sel, cap;
    logic [1:0] cpi;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int cnt, thr, rises;
    logic [15:0] q[$];
    always #4 clk_in = ~clk_in;
    icc_pin_model src (.clk_in(clk_in), .pin_out(pin));
    icc_channel dut (.clk_in(clk_in), .reset_in(reset_in), .capture_pin_in(pin),
        .cpu_idle_in(idle), .cpu_sleep_in(sleep), .timer_b_in(tb), .timer_c_in(tc),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .irq_out(irq));
    task automatic give_verdict;
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard: whole run needs well under this
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_irq(input logic e);
        // let the edge's register updates settle before looking
        #1;
        checks++;
        if (irq !== e) begin
            n_fail++;
            $display("BAD irq exp %b seen %b", e, irq);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // fresh timer values, then one pin change; expected latch noted
    task automatic hit(input logic lvl);
        @(posedge clk_in);
        tb <= 16'($urandom);
        tc <= 16'($urandom);
        src.drive(lvl);
        exp = sel ? tb : tc;
    endtask
    function automatic logic [15:0] ctl(logic s, logic t, logic [1:0] c, logic o, logic b,
        logic [2:0] m);
        return {2'b00, s, 5'h00, t, c, o, b, m};
    endfunction
    function automatic logic takes(int m, logic rise, int r);
        case (m)
            1: return 1'b1;
            2: return !rise;
            3: return rise;
            4: return rise && (r % 4 == 0);
            5: return rise && (r % 16 == 0);
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        void'($urandom(32'hE4EE75F2));
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        chk_irq(1'b0);
        rreg(ICC_OFF_CONTROL);
        chk("control", 16'h0000, got);
        wreg(ICC_OFF_CONTROL, 16'hFFFF);
        rreg(ICC_OFF_CONTROL);
        chk("control", 16'h20E7, got);
        wreg(4'h9, 16'hFFFF);
        rreg(4'h9);
        chk("unmapped", 16'h0000, got);
        wreg(ICC_OFF_IRQ_MASK, 16'h0001);
        for (int m = 0; m < 8; m++) begin
            sel = 1'($urandom);
            cpi = 2'($urandom);
            wreg(ICC_OFF_CONTROL, 16'h0000);
            wreg(ICC_OFF_IRQ_STATUS, 16'h0007);
            wreg(ICC_OFF_CONTROL, ctl(1'b0, sel, cpi, 1'b0, 1'b0, 3'(m)));
            cnt = 0;
            rises = 0;
            thr = (m == 1) ? 1 : int'(cpi) + 1;
            for (int e = 0; e < 32; e++) begin
                hit(e % 2 == 0);
                rises += (e % 2 == 0) ? 1 : 0;
                cap = takes(m, e % 2 == 0, rises);
                rreg(ICC_OFF_CONTROL);
                chk("control", ctl(1'b0, sel, cpi, 1'b0, cap, 3'(m)), got);
                if (cap) begin
                    cnt++;
                    rreg(ICC_OFF_BUFFER);
                    chk("buffer", exp, got);
                end
                chk_irq(cnt >= thr);
            end
        end
        sel = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wreg(ICC_OFF_CONTROL, 16'h0000);
            wreg(ICC_OFF_IRQ_STATUS, 16'h0007);
            wreg(ICC_OFF_CONTROL, ctl(1'b0, 1'b1, 2'(k), 1'b0, 1'b0, 3'h3));
            q.delete();
            for (int i = 0; i < 5; i++) begin
                hit(1'b1);
                q.push_back(exp);
                hit(1'b0);
                chk_irq(i >= k);
            end
            rreg(ICC_OFF_CONTROL);
            chk("control", ctl(1'b0, 1'b1, 2'(k), 1'b1, 1'b1, 3'h3), got);
            rreg(ICC_OFF_IRQ_STATUS);
            chk("status", 16'h0003, got);
            for (int i = 0; i < 4; i++) begin
                rreg(ICC_OFF_BUFFER);
                chk("buffer", q[i], got);
            end
            rreg(ICC_OFF_CONTROL);
            chk("control", ctl(1'b0, 1'b1, 2'(k), 1'b0, 1'b0, 3'h3), got);
            wreg(ICC_OFF_IRQ_STATUS, 16'h0001);
            chk_irq(1'b0);
        end
        wreg(ICC_OFF_CONTROL, 16'h0000);
        wreg(ICC_OFF_IRQ_MASK, 16'h0004);
        @(posedge clk_in);
        idle <= 1'b1;
        wreg(ICC_OFF_CONTROL, ctl(1'b1, 1'b1, 2'b00, 1'b0, 1'b0, 3'h3));
        hit(1'b1);
        hit(1'b0);
        rreg(ICC_OFF_CONTROL);
        chk("control", ctl(1'b1, 1'b1, 2'b00, 1'b0, 1'b0, 3'h3), got);
        wreg(ICC_OFF_CONTROL, ctl(1'b0, 1'b1, 2'b00, 1'b0, 1'b0, 3'h3));
        hit(1'b1);
        hit(1'b0);
        rreg(ICC_OFF_CONTROL);
        chk("control", ctl(1'b0, 1'b1, 2'b00, 1'b0, 1'b1, 3'h3), got);
        wreg(ICC_OFF_CONTROL, 16'h0000);
        wreg(ICC_OFF_CONTROL, 16'h2007);
        hit(1'b1);
        hit(1'b0);
        chk_irq(1'b1);
        wreg(ICC_OFF_IRQ_STATUS, 16'h0007);
        idle <= 1'b0;
        hit(1'b1);
        hit(1'b0);
        chk_irq(1'b0);
        sleep <= 1'b1;
        hit(1'b1);
        chk_irq(1'b1);
        rreg(ICC_OFF_IRQ_STATUS);
        chk("status", 16'h0004, got);
        give_verdict();
    end
endmodule // icc_channel_tb_top
`default_nettype wire
